//--- verilog/rcs_defines.vh
`ifndef RCS_DEFINES_VH
`define RCS_DEFINES_VH

// Register byte offsets
`define RCS_OFF_CTRL      8'h00
`define RCS_OFF_STATUS    8'h04
`define RCS_OFF_RFRAME    8'h08
`define RCS_OFF_START_MS  8'h0C
`define RCS_OFF_MSG_FRAME 8'h10
`define RCS_OFF_MSG_SEC   8'h14
`define RCS_OFF_FCOUNT    8'h18
`define RCS_OFF_SEL       8'h1C
`define RCS_OFF_NEW       8'h20
`define RCS_OFF_CUR       8'h24

// Field positions
`define RCS_CTRL_ARM      0
`define RCS_CTRL_CLRCNT   1
`define RCS_STAT_PENDING  0
`define RCS_STAT_DONE     1
`define RCS_STAT_LATE     2
`define RCS_DESC_LISTED   16
`define RCS_DESC_TYPE_LO  17
`define RCS_DESC_TYPE_HI  19

// Stream types
`define RCS_TYPE_MSC      3'h0
`define RCS_TYPE_CONTRIB  3'h1
`define RCS_TYPE_FIG      3'h2
`define RCS_TYPE_FIB_ASYN 3'h3
`define RCS_TYPE_FIB_SYNC 3'h4

// Frame scheduling
`define RCS_LEAD_FRAMES   15
`define RCS_DATA_FRAME_COUNT_MOD      5000
`define RCS_MS_PER_SEC    1000
`define RCS_MS_HALF_SEC   500

// Reset values
`define RCS_RST_WORD      32'h00000000

`endif

//--- verilog/rcs_stream_slot.v
`timescale 1ns/100ps
`default_nettype none
`include "rcs_defines.vh"

module rcs_stream_slot #(
  parameter LEN_W = 16
) (
  // Clock and reset
  input  wire             sys_clk_in,
  input  wire             rstn_in,
  // Frame timing
  input  wire             frame_in,
  input  wire             hit_r_in,
  input  wire             hit_lead_in,
  // Pending configuration
  input  wire             new_listed_in,
  input  wire [LEN_W-1:0] new_len_in,
  input  wire [2:0]       new_type_in,
  // Configuration in force
  output reg              listed_out,
  output reg  [LEN_W-1:0] len_out,
  output reg  [2:0]       type_out
);

  wire is_msc    = (type_out == `RCS_TYPE_MSC);
  wire is_sync   = (type_out == `RCS_TYPE_FIB_SYNC);
  wire shrinking = !new_listed_in || (new_len_in < len_out);

  // Per-frame update of one stream descriptor
  always @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      listed_out <= 1'b0;
      len_out    <= {LEN_W{1'b0}};
      type_out   <= `RCS_TYPE_MSC;
    end else if (frame_in) begin
      if (hit_r_in) begin
        // Listing and type only move at the instant
        listed_out <= new_listed_in;
        type_out   <= new_type_in;
        if (!listed_out || is_msc)
          len_out <= new_listed_in ? new_len_in : {LEN_W{1'b0}};
      end else if (is_msc && hit_lead_in && listed_out && shrinking) begin
        // Departing stream stays listed but carries nothing; shrinking stream takes its new length
        len_out <= new_listed_in ? new_len_in : {LEN_W{1'b0}};
      end
      // Listed loosely timed streams follow the table any frame but the instant
      if (listed_out && !is_msc && !is_sync && !hit_r_in)
        len_out <= new_len_in;
      // Sync block streams sit on a fixed grid: untouched here
      // Equal lengths give identical frames, so protection-only edits vanish
    end
  end

endmodule // rcs_stream_slot

`default_nettype wire

//--- verilog/rcs_scheduler.v
`timescale 1ns/100ps
`default_nettype none
`include "rcs_defines.vh"

// Notes on behaviour
// - New sub-channel stream appears at frame R
// - Removed stream length drops at R-15
// - Growing stream takes new length at R
// - Shrinking stream takes new length at R-15
// - Leaving stream listed to R-1, length zero
// - Length field changes exactly at scheduled frame
// - Descriptor set changes at frame R
// - Stream count changes only at instant
// - Protection-only change leaves frame unchanged
// - Component-count-only change leaves frame unchanged
// - Contribution and loose streams change any frame but R
// - Synchronous block stream length fixed once listed; listing and type still change at R
// - Request message frame field equals R
// - Request message time rounded to seconds

module rcs_scheduler #(
  parameter N_STREAMS = 8,
  parameter LEN_W     = 16,
  parameter CNT_W     = 16,
  parameter DATA_FRAME_COUNT_MOD  = `RCS_DATA_FRAME_COUNT_MOD
) (
  // Clock and reset
  input  wire                       sys_clk_in,
  input  wire                       rstn_in,
  // Avalon-MM slave
  input  wire [7:0]                 avs_address_in,
  input  wire                       avs_read_in,
  input  wire                       avs_write_in,
  input  wire [31:0]                avs_writedata_in,
  output reg  [31:0]                avs_readdata_out,
  output wire                       avs_waitrequest_out,
  // Frame generator side
  input  wire                       frame_start_in,
  output reg                        frame_valid_out,
  output reg  [CNT_W-1:0]           frame_count_out,
  output wire [N_STREAMS-1:0]       stream_listed_out,
  output wire [N_STREAMS*LEN_W-1:0] stream_length_out,
  output wire [N_STREAMS*3-1:0]     stream_type_out,
  // Reconfiguration request message fields
  output reg  [CNT_W-1:0]           msg_frame_count_out,
  output reg  [31:0]                msg_seconds_out
);

  localparam SEL_W = (N_STREAMS > 1) ? $clog2(N_STREAMS) : 1;
  localparam [CNT_W-1:0] MOD_C  = DATA_FRAME_COUNT_MOD;
  localparam [CNT_W-1:0] LEAD_C = `RCS_LEAD_FRAMES;
  localparam [CNT_W-1:0] ONE_C  = 1;

  // Schedule state
  reg              armed;
  reg              done;
  reg              late;
  reg [CNT_W-1:0]  r_frame;
  reg [31:0]       start_ms;
  reg [SEL_W-1:0]  sel;
  reg              ack;

  // Pending table, one entry per stream
  reg [LEN_W-1:0]  new_len    [0:N_STREAMS-1];
  reg              new_listed [0:N_STREAMS-1];
  reg [2:0]        new_type   [0:N_STREAMS-1];

  wire [LEN_W-1:0] cur_len    [0:N_STREAMS-1];
  wire             cur_listed [0:N_STREAMS-1];
  wire [2:0]       cur_type   [0:N_STREAMS-1];

  // Bus handshake: one wait state per access
  wire req    = avs_read_in | avs_write_in;
  wire wr_go  = avs_write_in & ack;
  // Full word offset, so high addresses never alias onto the control word
  wire [7:0] off = {avs_address_in[7:2], 2'b00};
  assign avs_waitrequest_out = req & ~ack;

  // Frame count of the frame about to be sent
  wire [CNT_W-1:0] next_count = (frame_count_out + ONE_C >= MOD_C) ?
                                {CNT_W{1'b0}} : frame_count_out + ONE_C;

  // R minus lead, wrapped around the count range
  wire [CNT_W-1:0] lead_frame = (r_frame >= LEAD_C) ? r_frame - LEAD_C :
                                r_frame + MOD_C - LEAD_C;
  wire hit_r    = armed & (next_count == r_frame);
  wire hit_lead = armed & (next_count == lead_frame);

  // Rounded seconds of the requested start time
  wire [32:0] ms_round = {1'b0, start_ms} + `RCS_MS_HALF_SEC;
  wire [32:0] secs_w   = ms_round / `RCS_MS_PER_SEC;

  // Frame counter; a write to the clear bit restarts at zero
  always @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      frame_count_out <= {CNT_W{1'b0}};
      frame_valid_out <= 1'b0;
    end else begin
      frame_valid_out <= frame_start_in;
      if (wr_go && off == `RCS_OFF_CTRL && avs_writedata_in[`RCS_CTRL_CLRCNT])
        frame_count_out <= {CNT_W{1'b0}};
      else if (frame_start_in)
        frame_count_out <= next_count;
    end
  end

  // Arm, schedule registers and message fields
  always @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      armed               <= 1'b0;
      done                <= 1'b0;
      late                <= 1'b0;
      r_frame             <= {CNT_W{1'b0}};
      start_ms            <= `RCS_RST_WORD;
      sel                 <= {SEL_W{1'b0}};
      msg_frame_count_out <= {CNT_W{1'b0}};
      msg_seconds_out     <= `RCS_RST_WORD;
    end else begin
      if (wr_go && off == `RCS_OFF_RFRAME && !armed)
        r_frame <= avs_writedata_in[CNT_W-1:0];
      if (wr_go && off == `RCS_OFF_START_MS && !armed)
        start_ms <= avs_writedata_in;
      if (wr_go && off == `RCS_OFF_SEL)
        sel <= avs_writedata_in[SEL_W-1:0];
      // Arming latches the request message fields
      if (wr_go && off == `RCS_OFF_CTRL && avs_writedata_in[`RCS_CTRL_ARM] && !armed) begin
        armed               <= 1'b1;
        msg_frame_count_out <= r_frame;
        msg_seconds_out     <= secs_w[31:0];
      end else if (frame_start_in && hit_r) begin
        armed <= 1'b0;
      end
      // A lead frame seen after arming marks the shrink as on time
      if (frame_start_in && armed && hit_lead)
        late <= 1'b0;
      else if (wr_go && off == `RCS_OFF_CTRL && avs_writedata_in[`RCS_CTRL_ARM] && !armed)
        late <= 1'b1;
      // Done is sticky; a set in the same cycle beats a clear
      if (frame_start_in && hit_r)
        done <= 1'b1;
      else if (wr_go && off == `RCS_OFF_STATUS && avs_writedata_in[`RCS_STAT_DONE])
        done <= 1'b0;
    end
  end

  // Pending table writes and per-stream slots
  genvar g;
  generate
    for (g = 0; g < N_STREAMS; g = g + 1) begin : g_stream
      always @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
          new_len[g]    <= {LEN_W{1'b0}};
          new_listed[g] <= 1'b0;
          new_type[g]   <= `RCS_TYPE_MSC;
        end else if (wr_go && off == `RCS_OFF_NEW && sel == g) begin
          new_len[g]    <= avs_writedata_in[LEN_W-1:0];
          new_listed[g] <= avs_writedata_in[`RCS_DESC_LISTED];
          new_type[g]   <= avs_writedata_in[`RCS_DESC_TYPE_HI:`RCS_DESC_TYPE_LO];
        end
      end

      rcs_stream_slot #(
        .LEN_W (LEN_W)
      ) u_slot (
        .sys_clk_in    (sys_clk_in),
        .rstn_in       (rstn_in),
        .frame_in      (frame_start_in),
        .hit_r_in      (hit_r),
        .hit_lead_in   (hit_lead),
        .new_listed_in (new_listed[g]),
        .new_len_in    (new_len[g]),
        .new_type_in   (new_type[g]),
        .listed_out    (cur_listed[g]),
        .len_out       (cur_len[g]),
        .type_out      (cur_type[g])
      );

      assign stream_listed_out[g]                 = cur_listed[g];
      assign stream_length_out[g*LEN_W +: LEN_W] = cur_len[g];
      assign stream_type_out[g*3 +: 3]           = cur_type[g];
    end
  endgenerate

  // Read mux; data is captured in the wait cycle and held for the ack edge
  reg [31:0] rd_mux;
  always @* begin
    rd_mux = 32'h00000000;
    case (off)
      `RCS_OFF_CTRL:      rd_mux[`RCS_CTRL_ARM] = armed;
      `RCS_OFF_STATUS: begin
        rd_mux[`RCS_STAT_PENDING] = armed;
        rd_mux[`RCS_STAT_DONE]    = done;
        rd_mux[`RCS_STAT_LATE]    = late;
      end
      `RCS_OFF_RFRAME:    rd_mux[CNT_W-1:0] = r_frame;
      `RCS_OFF_START_MS:  rd_mux = start_ms;
      `RCS_OFF_MSG_FRAME: rd_mux[CNT_W-1:0] = msg_frame_count_out;
      `RCS_OFF_MSG_SEC:   rd_mux = msg_seconds_out;
      `RCS_OFF_FCOUNT:    rd_mux[CNT_W-1:0] = frame_count_out;
      `RCS_OFF_SEL:       rd_mux[SEL_W-1:0] = sel;
      `RCS_OFF_NEW: begin
        rd_mux[LEN_W-1:0]        = new_len[sel];
        rd_mux[`RCS_DESC_LISTED] = new_listed[sel];
        rd_mux[`RCS_DESC_TYPE_HI:`RCS_DESC_TYPE_LO] = new_type[sel];
      end
      `RCS_OFF_CUR: begin
        rd_mux[LEN_W-1:0]        = cur_len[sel];
        rd_mux[`RCS_DESC_LISTED] = cur_listed[sel];
        rd_mux[`RCS_DESC_TYPE_HI:`RCS_DESC_TYPE_LO] = cur_type[sel];
      end
      default:            rd_mux = 32'h00000000;
    endcase
  end

  // Bus acknowledge and read data register
  always @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      ack              <= 1'b0;
      avs_readdata_out <= `RCS_RST_WORD;
    end else begin
      ack <= req & ~ack;
      if (avs_read_in && !ack)
        avs_readdata_out <= rd_mux;
    end
  end

endmodule // rcs_scheduler

`default_nettype wire

//--- verilog/rcs_unused_placeholder_none.v
`timescale 1ns/100ps
`default_nettype none
`default_nettype wire

//--- test/rcs_scheduler_sva.sv
`timescale 1ns/100ps
`default_nettype none
module rcs_scheduler_sva #(
  parameter N_STREAMS = 8,
  parameter LEN_W     = 16,
  parameter CNT_W     = 16,
  parameter DATA_FRAME_COUNT_MOD  = 5000
) (
  // Clock and reset
  input wire logic                       sys_clk_in,
  input wire logic                       rstn_in,
  // Bus
  input wire logic [7:0]                 avs_address_in,
  input wire logic                       avs_read_in,
  input wire logic                       avs_write_in,
  input wire logic [31:0]                avs_writedata_in,
  input wire logic [31:0]                avs_readdata_out,
  input wire logic                       avs_waitrequest_out,
  // Frame side
  input wire logic                       frame_start_in,
  input wire logic                       frame_valid_out,
  input wire logic [CNT_W-1:0]           frame_count_out,
  input wire logic [N_STREAMS-1:0]       stream_listed_out,
  input wire logic [N_STREAMS*LEN_W-1:0] stream_length_out,
  input wire logic [N_STREAMS*3-1:0]     stream_type_out,
  input wire logic [CNT_W-1:0]           msg_frame_count_out,
  input wire logic [31:0]                msg_seconds_out
);
  // Instant and lead frame; stream 0 is kept a main channel stream by the bench
  wire [CNT_W-1:0] r_lead = CNT_W'((msg_frame_count_out + DATA_FRAME_COUNT_MOD - 15) % DATA_FRAME_COUNT_MOD);
  wire             at_r   = (frame_count_out == msg_frame_count_out);
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!rstn_in);
  a_wait_state: assert property ($rose(avs_read_in | avs_write_in) |->
    avs_waitrequest_out ##1 !avs_waitrequest_out) else $error("bus wait state wrong");
  a_valid_pulse: assert property (frame_start_in |=> frame_valid_out) else $error("no valid");
  a_valid_cause: assert property (frame_valid_out |-> $past(frame_start_in))
    else $error("valid without frame");
  a_count_step: assert property (frame_start_in |=> frame_count_out ==
    CNT_W'(($past(frame_count_out) + 1) % DATA_FRAME_COUNT_MOD)) else $error("count step wrong");
  a_len_hold: assert property (!frame_start_in |=> $stable(stream_length_out)
    && $stable(stream_listed_out)) else $error("streams changed between frames");
  a_list_at_r: assert property ($changed(stream_listed_out) |-> at_r)
    else $error("listing changed off the instant");
  a_type_at_r: assert property ($changed(stream_type_out) |-> at_r)
    else $error("descriptor changed off the instant");
  a_msc_len: assert property ($changed(stream_length_out[LEN_W-1:0]) &&
    stream_type_out[2:0] == 3'h0 |-> at_r || frame_count_out == r_lead)
    else $error("main stream length off schedule");
  a_grow_at_r: assert property (stream_type_out[2:0] == 3'h0 &&
    stream_length_out[LEN_W-1:0] > $past(stream_length_out[LEN_W-1:0]) |-> at_r)
    else $error("growth off the instant");
  a_sync_fixed: assert property (stream_type_out[5:3] == 3'h4 &&
    $past(stream_type_out[5:3]) == 3'h4 |-> $stable(stream_length_out[2*LEN_W-1:LEN_W]))
    else $error("sync block stream altered");
  // Main scenarios reached
  c_instant: cover property (frame_valid_out && at_r);
  c_lead: cover property (frame_valid_out && frame_count_out == r_lead);
  c_leave: cover property ($fell(stream_listed_out[0]));
endmodule // rcs_scheduler_sva
bind rcs_scheduler rcs_scheduler_sva #(.N_STREAMS(N_STREAMS), .LEN_W(LEN_W), .CNT_W(CNT_W),
  .DATA_FRAME_COUNT_MOD(DATA_FRAME_COUNT_MOD)) u_sva (.sys_clk_in(sys_clk_in), .rstn_in(rstn_in),
  .avs_address_in(avs_address_in), .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
  .avs_writedata_in(avs_writedata_in), .avs_readdata_out(avs_readdata_out),
  .avs_waitrequest_out(avs_waitrequest_out), .frame_start_in(frame_start_in),
  .frame_valid_out(frame_valid_out), .frame_count_out(frame_count_out),
  .stream_listed_out(stream_listed_out), .stream_length_out(stream_length_out),
  .stream_type_out(stream_type_out), .msg_frame_count_out(msg_frame_count_out),
  .msg_seconds_out(msg_seconds_out));
`default_nettype wire

//--- test/rcs_mux_model.sv
`timescale 1ns/100ps
`default_nettype none
module rcs_mux_model #(
  parameter MOD = 64
) (
  // Clock and reset
  input  wire logic        sys_clk_in,
  input  wire logic        rstn_in,
  // Pacing and observed frames
  input  wire logic [2:0]  gap_in,
  input  wire logic        frame_valid_in,
  input  wire logic [15:0] count_in,
  output logic             frame_start_out,
  output logic             skip_out
);
  logic [2:0]  wait_cnt;
  logic [15:0] last;
  logic        seen;
  // Paces frames; a slow gap stretches each frame so bus traffic lands mid-frame
  always @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      wait_cnt <= 3'h0;
      frame_start_out <= 1'b0;
      last <= 16'h0000;
      seen <= 1'b0;
      skip_out <= 1'b0;
    end else begin
      frame_start_out <= (wait_cnt == 3'h0);
      wait_cnt <= (wait_cnt == 3'h0) ? gap_in : wait_cnt - 3'h1;
      // Switches by frame count only, never by the coarse seconds field
      if (frame_valid_in) begin
        seen <= 1'b1;
        last <= count_in;
        if (seen && count_in != 16'((last + 16'h0001) % MOD)) skip_out <= 1'b1;
      end
    end
  end
endmodule // rcs_mux_model
`default_nettype wire

//--- test/testbench.sv
`timescale 1ns/100ps
`default_nettype none
module testbench;
  localparam MOD = 64;
  logic sys_clk_in, rstn_in, avs_read_in, avs_write_in;
  logic [7:0] avs_address_in;
  logic [31:0] avs_writedata_in, q, ms;
  logic [2:0] gap;
  logic [15:0] r_val, c2, ln;
  logic [15:0] lens [0:5];
  logic lst;
  wire [31:0] avs_readdata_out, msg_seconds_out;
  wire avs_waitrequest_out, frame_start_in, frame_valid_out, skip;
  wire [15:0] frame_count_out, msg_frame_count_out;
  wire [7:0] stream_listed_out;
  wire [127:0] stream_length_out;
  wire [23:0] stream_type_out;
  int bad_count, check_count, k, n;
  rcs_scheduler #(.DATA_FRAME_COUNT_MOD(MOD)) DUT (.sys_clk_in(sys_clk_in), .rstn_in(rstn_in),
    .avs_address_in(avs_address_in), .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
    .avs_writedata_in(avs_writedata_in), .avs_readdata_out(avs_readdata_out),
    .avs_waitrequest_out(avs_waitrequest_out), .frame_start_in(frame_start_in),
    .frame_valid_out(frame_valid_out), .frame_count_out(frame_count_out),
    .stream_listed_out(stream_listed_out), .stream_length_out(stream_length_out),
    .stream_type_out(stream_type_out), .msg_frame_count_out(msg_frame_count_out),
    .msg_seconds_out(msg_seconds_out));
  rcs_mux_model #(.MOD(MOD)) u_mux (.sys_clk_in(sys_clk_in), .rstn_in(rstn_in), .gap_in(gap),
    .frame_valid_in(frame_valid_out), .count_in(frame_count_out),
    .frame_start_out(frame_start_in), .skip_out(skip));
  // Clock
  initial begin
    sys_clk_in = 1'b0;
    forever #5 sys_clk_in = ~sys_clk_in;
  end
  task automatic close_out;
    $display("comparisons %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input string what, input [31:0] exp, input [31:0] got);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected %s: expected %0h seen %0h", what, exp, got);
    end
  endtask
  // One bus access; held until waitrequest is seen low at a rising edge
  task automatic bus(input bit wr, input [7:0] a, input [31:0] d);
    @(posedge sys_clk_in);
    avs_address_in <= a;
    avs_writedata_in <= d;
    avs_read_in <= !wr;
    avs_write_in <= wr;
    do @(posedge sys_clk_in);
    while (avs_waitrequest_out !== 1'b0);
    q = avs_readdata_out;
    avs_read_in <= 1'b0;
    avs_write_in <= 1'b0;
  endtask
  task automatic set_desc(input [31:0] idx, input [31:0] d);
    bus(1, 8'h1C, idx);
    bus(1, 8'h20, d);
  endtask
  // Returns at a falling edge inside the cycle where the new frame stands
  task automatic next_frame;
    n = 0;
    do begin
      @(negedge sys_clk_in);
      n++;
    end while (frame_valid_out !== 1'b1 && n < 60);
  endtask
  // Listed flag and length of stream 0 for a frame of count c
  function automatic [16:0] exp0(input [15:0] c, input bit ol, input bit nl,
                                 input [15:0] olen, input [15:0] nlen);
    logic [5:0] d;
    d = r_val[5:0] - c[5:0];
    if (d == 6'h00) return {nl, nlen};
    if (d <= 6'h0F && (!nl || nlen < olen)) return {ol, nlen};
    return {ol, olen};
  endfunction
  // Watchdog
  initial begin
    repeat (20000) @(posedge sys_clk_in);
    bad_count++;
    close_out;
  end
  initial begin
    void'($urandom(99132));
    {rstn_in, avs_read_in, avs_write_in, avs_address_in, avs_writedata_in} = '0;
    gap = 3'h2;
    c2 = 16'h0020;
    repeat (6) @(posedge sys_clk_in);
    rstn_in <= 1'b1;
    bus(0, 8'h04, 0);
    chk("status", 0, q);
    bus(1, 8'h3C, 32'h0000FFFF);
    bus(0, 8'h3C, 0);
    chk("unmapped", 0, q);
    lens[0] = 0;
    lens[1] = 16'($urandom % 200 + 8);
    lens[2] = lens[1] + 16'($urandom % 50 + 1);
    lens[3] = lens[2];
    lens[4] = lens[3] - 16'($urandom % 8 + 1);
    lens[5] = 0;
    // Side streams join with the first change: synchronous block and contribution
    set_desc(1, 32'h00090030);
    set_desc(2, 32'h00030020);
    // Steps: add, grow, same length, shrink, remove
    for (k = 0; k < 5; k++) begin
      gap <= 3'($urandom % 5 + 2);
      set_desc(0, {12'h000, 3'h0, k < 4, lens[k+1]});
      if (k == 2) begin
        c2 = 16'($urandom % 64 + 1);
        set_desc(2, 32'h00030000 | c2);
      end
      next_frame;
      r_val = 16'((frame_count_out + 20) % MOD);
      ms = $urandom % 100000;
      if (ms % 1000 == 500) ms++;
      bus(1, 8'h08, r_val);
      bus(1, 8'h0C, ms);
      bus(1, 8'h00, 1);
      // Armed well before the lead frame: pending and late both stand
      bus(0, 8'h04, 0);
      chk("armed status", 32'h5, q);
      do begin
        next_frame;
        {lst, ln} = exp0(frame_count_out, k > 0, k < 4, lens[k], lens[k+1]);
        chk("listed0", lst, stream_listed_out[0]);
        chk("length0", ln, stream_length_out[15:0]);
      end while (frame_count_out !== r_val && n < 60);
      chk("msg frame", r_val, msg_frame_count_out);
      chk("msg seconds", (ms + 500) / 1000, msg_seconds_out);
      chk("length1", 16'h0030, stream_length_out[31:16]);
      chk("length2", c2, stream_length_out[47:32]);
      chk("type1", 3'h4, stream_type_out[5:3]);
      bus(0, 8'h04, 0);
      chk("status", 32'h2, q);
      bus(1, 8'h04, 32'h2);
      // Descriptor in force for stream 0 read back over the bus
      bus(1, 8'h1C, 0);
      bus(0, 8'h24, 0);
      chk("current0", {12'h000, 3'h0, k < 4, lens[k+1]}, q);
      $display("step %0d finished at frame %0d", k, r_val);
    end
    chk("frame sequence", 0, skip);
    // Slow frames so the clear never meets a frame start in one cycle
    gap <= 3'h6;
    next_frame;
    next_frame;
    bus(1, 8'h00, 32'h2);
    bus(0, 8'h18, 0);
    chk("cleared count", 0, q);
    close_out;
  end
endmodule // testbench
`default_nettype wire
